// *** design/fan_ctl_pkg.sv ***
package fan_ctl_pkg;

  // register word addresses (byte address = index * 4)
  localparam logic [7:0] ADDR_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_CFG4     = 8'h04;
  localparam logic [7:0] ADDR_CFG1     = 8'h10;
  localparam logic [7:0] ADDR_DUTY     = 8'h11;
  localparam logic [7:0] ADDR_FANCHAR  = 8'h20;
  localparam logic [7:0] ADDR_RAMP     = 8'h23;
  localparam logic [7:0] ADDR_TARGET   = 8'h30;
  localparam logic [7:0] ADDR_LOWLIM   = 8'h31;
  localparam logic [7:0] ADDR_MEASURED = 8'h32;
  localparam logic [7:0] ADDR_TEMPDUTY = 8'h33;

  // field positions
  localparam int SLOW_BIT     = 1;
  localparam int MEAS_EN_BIT  = 2;
  localparam int TPM_BIT      = 1;
  localparam int FAST_BIT     = 5;
  localparam int SPDIS_BIT    = 5;
  localparam int STEP_LSB     = 5;
  localparam int MEAS_REQ_BIT = 0;
  localparam int SPINNING_BIT = 3;

  // reset values
  localparam logic [2:0]  SPIN_TIME_RST = 3'h5;
  localparam logic [1:0]  CTL_SEL_RST   = 2'h2;
  localparam logic [7:0]  STATUS_RST    = 8'h04;

  // duty figures on a 0..255 scale, plus the tach count tolerance SPEED_TOL
  localparam logic [7:0]  DUTY_THIRD = 8'h55;
  localparam logic [7:0]  DUTY_FULL  = 8'hFF;
  localparam logic [7:0]  DUTY_7PCT  = 8'h12;
  localparam logic [7:0]  DUTY_30PCT = 8'h4D;
  localparam logic [15:0] SPEED_TOL  = 16'h000A;
  localparam int          RAMP_STEPS = 170;

  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int SPIN_UNIT_MS  = 200;
  localparam int SLOW_MS       = 1000;
  localparam int FAST_MS       = 250;
  localparam int UNIT_CYC      = CLK_HZ / 1000 * SPIN_UNIT_MS;
  localparam int SLOW_CYC      = CLK_HZ / 1000 * SLOW_MS;
  localparam int FAST_CYC      = CLK_HZ / 1000 * FAST_MS;

  typedef enum logic [2:0] {
    MODE_OPEN = 3'b001,
    MODE_REG  = 3'b010,
    MODE_AUTO = 3'b100
  } ctl_mode_t;

  typedef enum logic [1:0] {
    SPIN_IDLE = 2'b01,
    SPIN_RUN  = 2'b10
  } spin_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;

endpackage : fan_ctl_pkg

// *** design/fan_spinup_and_speed_mode_ctl.sv ***
`timescale 1ns/1ps
// Behaviour
// - spin up when fan must start from stop or is seen below minimum speed
// - first third of spin-up ramps duty 33.3% to 100%, then holds 100%
// - spin-up ends at 33.3%, then the selected normal mode takes over
// - spin_time_sel picks 0.2..8 s spin-up length, default code 101
// - a speed measurement starts right after every spin-up
// - spinup_disable set blocks all spin-up sequences
// - spinup_disable resets to 0 and spin-up runs regardless of slow flag
// - no fan-slow detection while spin-up runs
// - slow flag clears only on read, resets on next slow monitoring pass
// - slow flag stays set after spin-up until it is read
// - open-loop mode outputs host duty value right after the write
// - open-loop, measuring, tach mode 0: duty below 7% forced to 0%
// - open-loop, not measuring or tach mode 1: low duty kept as written
// - regulation mode adjusts duty while measured and target counts differ
// - regulation only runs while speed measurement is enabled
// - regulation pass once per second, or every 250 ms in fast rate
// - each regulation adjustment limited to duty_step_size
// - regulation stops when count difference is at most 0x000A
// - regulation, tach mode 0: desired duty below 30% forced to 30%
// - auto modes follow remote or highest calculated temperature speed
// - control code 10 (default) remote auto, 11 highest-of-both auto
// - duty_step_size selects 1/255 to 4/255 per update
// - slow flag set when measured count exceeds low speed limit
module fan_spinup_and_speed_mode_ctl
  import fan_ctl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] measured_speed_count,
  input  wire logic        speed_count_valid,
  input  wire logic        fan_start_req,
  input  wire logic [7:0]  remote_temp_duty,
  input  wire logic [7:0]  local_temp_duty,
  output logic      [7:0]  fan_pwm_duty,
  output logic             speed_measure_start,
  output logic             spinup_active
);

  avmm_req_t   req;
  logic        ack_ff;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  fan_drive_ctl_sel_ff;
  logic [2:0]  spin_time_sel_ff;
  logic        spinup_disable_ff;
  logic [1:0]  duty_step_size_ff;
  logic [7:0]  duty_value_reg_ff;
  logic        meas_en_ff;
  logic        tach_power_mode_ff;
  logic        fast_monitor_rate_ff;
  logic        fan_slow_flag_ff;
  logic [15:0] target_speed_count_ff;
  logic [15:0] low_limit_ff;
  logic [15:0] meas_ff;
  logic [7:0]  reg_duty_ff;
  logic [31:0] rdata_ff;
  spin_state_t spin_ff;
  logic [31:0] spin_cnt_ff;
  logic [31:0] spin_len;
  logic [7:0]  ramp_duty;
  logic        spin_done;
  logic [31:0] mon_cnt_ff;
  logic        mon_tick;
  logic        meas_start_ff;
  logic        slow_now;
  logic        start_spin;
  logic        rd_status;
  ctl_mode_t   mode;
  logic [7:0]  open_duty;
  logic [7:0]  auto_duty;
  logic [7:0]  norm_duty;
  logic [15:0] diff;
  logic [8:0]  step;
  logic [8:0]  reg_up;
  logic [8:0]  reg_dn;
  logic [7:0]  nxt_reg_duty;
  logic [7:0]  pwm_ff;

  assign req = '{avs_read, avs_write, avs_address, avs_writedata};

  // one wait cycle on every access keeps read data registered
  assign avs_waitrequest = (req.read | req.write) & ~ack_ff;
  // writes and the clear-on-read land only on the accepting edge, where
  // waitrequest is low; read data is captured one edge earlier so it stands
  assign wr_en = req.write & ack_ff & avs_byteenable[0];
  assign rd_en = req.read & ~ack_ff;
  assign rd_status = req.read & ack_ff & (req.address == ADDR_STATUS);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (req.read | req.write) & ~ack_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fan_drive_ctl_sel_ff  <= CTL_SEL_RST;
      spin_time_sel_ff      <= SPIN_TIME_RST;
      spinup_disable_ff     <= 1'b0;
      duty_step_size_ff     <= 2'h0;
      duty_value_reg_ff     <= 8'h00;
      meas_en_ff            <= STATUS_RST[MEAS_EN_BIT];
      tach_power_mode_ff    <= 1'b0;
      fast_monitor_rate_ff  <= 1'b0;
      target_speed_count_ff <= 16'h0000;
      low_limit_ff          <= 16'hFFFF;
    end else if (wr_en) begin
      case (req.address)
        ADDR_CFG1:    fan_drive_ctl_sel_ff <= req.writedata[1:0];
        ADDR_DUTY:    duty_value_reg_ff <= req.writedata[7:0];
        ADDR_FANCHAR: begin
          spin_time_sel_ff  <= req.writedata[2:0];
          spinup_disable_ff <= req.writedata[SPDIS_BIT];
        end
        ADDR_RAMP:    duty_step_size_ff <= req.writedata[STEP_LSB +: 2];
        ADDR_STATUS: begin
          meas_en_ff         <= req.writedata[MEAS_EN_BIT];
          tach_power_mode_ff <= req.writedata[TPM_BIT];
        end
        ADDR_CFG4:    fast_monitor_rate_ff <= req.writedata[FAST_BIT];
        ADDR_TARGET:  target_speed_count_ff <= req.writedata[15:0];
        ADDR_LOWLIM:  low_limit_ff <= req.writedata[15:0];
        default: ;
      endcase
    end
  end

  // status word: slow flag shares the word with the tach controls
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      case (req.address)
        ADDR_STATUS:   rdata_ff <= {29'h0, meas_en_ff,
                                    fan_slow_flag_ff | slow_now,
                                    1'b0};
        ADDR_CFG4:     rdata_ff <= {26'h0, fast_monitor_rate_ff, 5'h0};
        ADDR_CFG1:     rdata_ff <= {30'h0, fan_drive_ctl_sel_ff};
        ADDR_DUTY:     rdata_ff <= {24'h0, duty_value_reg_ff};
        ADDR_FANCHAR:  rdata_ff <= {26'h0, spinup_disable_ff, 2'h0,
                                    spin_time_sel_ff};
        ADDR_RAMP:     rdata_ff <= {25'h0, duty_step_size_ff, 5'h0};
        ADDR_TARGET:   rdata_ff <= {16'h0, target_speed_count_ff};
        ADDR_LOWLIM:   rdata_ff <= {16'h0, low_limit_ff};
        ADDR_MEASURED: rdata_ff <= {16'h0, meas_ff};
        ADDR_TEMPDUTY: rdata_ff <= {28'h0, spinup_active, pwm_ff[7:5]};
        default:       rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meas_ff <= 16'h0000;
    end else if (speed_count_valid) begin
      meas_ff <= measured_speed_count;
    end
  end

  // spin-up length: codes 0..4 are n+1 units of 0.2 s, 5..7 double from 2 s
  always_comb begin
    case (spin_time_sel_ff)
      3'h5:    spin_len = 32'(UNIT_CYC * 10);
      3'h6:    spin_len = 32'(UNIT_CYC * 20);
      3'h7:    spin_len = 32'(UNIT_CYC * 40);
      default: spin_len = 32'(UNIT_CYC) * (32'(spin_time_sel_ff) + 32'd1);
    endcase
  end

  assign slow_now = speed_count_valid & (measured_speed_count > low_limit_ff)
                    & (spin_ff == SPIN_IDLE);
  assign start_spin = ~spinup_disable_ff & (spin_ff == SPIN_IDLE)
                      & (fan_start_req | slow_now);
  assign spin_done = (spin_ff == SPIN_RUN) & (spin_cnt_ff >= spin_len - 1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spin_ff     <= SPIN_IDLE;
      spin_cnt_ff <= 32'h0000_0000;
    end else begin
      case (spin_ff)
        SPIN_IDLE: begin
          spin_cnt_ff <= 32'h0000_0000;
          if (start_spin) begin
            spin_ff <= SPIN_RUN;
          end
        end
        SPIN_RUN: begin
          spin_cnt_ff <= spin_cnt_ff + 32'd1;
          if (spin_done) begin
            spin_ff <= SPIN_IDLE;
          end
        end
        default: spin_ff <= SPIN_IDLE;
      endcase
    end
  end
  assign spinup_active = (spin_ff == SPIN_RUN);

  // linear ramp across a third of the time; wide product avoids overflow
  always_comb begin
    logic [63:0] part;
    part = 64'(spin_cnt_ff) * 64'd3 * 64'(RAMP_STEPS);
    if (spin_cnt_ff * 32'd3 >= spin_len) begin
      ramp_duty = DUTY_FULL;
    end else begin
      ramp_duty = DUTY_THIRD + 8'(part / 64'(spin_len));
    end
  end

  // set wins over the clear-on-read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fan_slow_flag_ff <= 1'b0;
    end else if (slow_now) begin
      fan_slow_flag_ff <= 1'b1;
    end else if (rd_status) begin
      fan_slow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meas_start_ff <= 1'b0;
    end else begin
      meas_start_ff <= spin_done;
    end
  end
  assign speed_measure_start = meas_start_ff | mon_tick;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mon_cnt_ff <= 32'h0000_0000;
    end else if (spin_done || mon_tick) begin
      mon_cnt_ff <= 32'h0000_0000;
    end else begin
      mon_cnt_ff <= mon_cnt_ff + 32'd1;
    end
  end
  assign mon_tick = mon_cnt_ff >= (fast_monitor_rate_ff ? 32'(FAST_CYC - 1)
                                                        : 32'(SLOW_CYC - 1));

  always_comb begin
    case (fan_drive_ctl_sel_ff)
      2'h0:    mode = MODE_OPEN;
      2'h1:    mode = MODE_REG;
      default: mode = MODE_AUTO;
    endcase
  end

  assign open_duty = (meas_en_ff && !tach_power_mode_ff &&
                      duty_value_reg_ff < DUTY_7PCT) ? 8'h00
                                                     : duty_value_reg_ff;
  assign auto_duty = (fan_drive_ctl_sel_ff == 2'h3 &&
                      local_temp_duty > remote_temp_duty) ? local_temp_duty
                                                          : remote_temp_duty;

  assign diff = (meas_ff > target_speed_count_ff)
              ? meas_ff - target_speed_count_ff
              : target_speed_count_ff - meas_ff;
  assign step   = 9'(duty_step_size_ff) + 9'd1;
  assign reg_up = {1'b0, reg_duty_ff} + step;
  assign reg_dn = {1'b0, reg_duty_ff} - step;

  // larger count means slower fan, so raise duty when count is high
  always_comb begin
    nxt_reg_duty = reg_duty_ff;
    if (mon_tick && meas_en_ff && diff > SPEED_TOL) begin
      if (meas_ff > target_speed_count_ff) begin
        nxt_reg_duty = reg_up[8] ? DUTY_FULL : reg_up[7:0];
      end else begin
        nxt_reg_duty = reg_dn[8] ? 8'h00 : reg_dn[7:0];
      end
    end
    if (!tach_power_mode_ff && nxt_reg_duty < DUTY_30PCT) begin
      nxt_reg_duty = DUTY_30PCT;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_duty_ff <= DUTY_30PCT;
    end else if (spin_done) begin
      reg_duty_ff <= DUTY_THIRD;
    end else if (mode == MODE_REG) begin
      reg_duty_ff <= nxt_reg_duty;
    end
  end

  always_comb begin
    case (mode)
      MODE_OPEN: norm_duty = open_duty;
      MODE_REG:  norm_duty = meas_en_ff ? reg_duty_ff : pwm_ff;
      MODE_AUTO: norm_duty = auto_duty;
      default:   norm_duty = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_ff <= 8'h00;
    end else if (spinup_active) begin
      pwm_ff <= ramp_duty;
    end else if (meas_start_ff) begin
      pwm_ff <= DUTY_THIRD;
    end else begin
      pwm_ff <= norm_duty;
    end
  end
  assign fan_pwm_duty = pwm_ff;

  AST_SPIN_START: assert property (@(posedge ref_clk) disable iff (!nrst)
    start_spin |=> spinup_active ##1 pwm_ff == DUTY_THIRD)
    else $error("spin-up did not start at one third duty");
  AST_NO_SPIN_DIS: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(spinup_active) |-> $past(!spinup_disable_ff))
    else $error("spin-up ran while disabled");
  AST_END_THIRD: assert property (@(posedge ref_clk) disable iff (!nrst)
    spin_done |=> ##1 pwm_ff == DUTY_THIRD)
    else $error("duty not one third after spin-up");
  AST_MEAS_AFTER: assert property (@(posedge ref_clk) disable iff (!nrst)
    spin_done |=> speed_measure_start)
    else $error("no measurement after spin-up");
  AST_NO_SLOW_SPIN: assert property (@(posedge ref_clk) disable iff (!nrst)
    spinup_active |=> $stable(fan_slow_flag_ff) || !fan_slow_flag_ff)
    else $error("slow flag set during spin-up");
  AST_SLOW_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
    fan_slow_flag_ff && !rd_status |=> fan_slow_flag_ff)
    else $error("slow flag cleared without read");
  AST_OPEN_LOW: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode == MODE_OPEN && !spinup_active && !meas_start_ff && meas_en_ff
    && !tach_power_mode_ff && duty_value_reg_ff < DUTY_7PCT
    |=> pwm_ff == 8'h00)
    else $error("open-loop low duty not forced off");
  AST_REG_FLOOR: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode == MODE_REG && !tach_power_mode_ff && $past(mode == MODE_REG)
    && !$past(spin_done) |-> reg_duty_ff >= DUTY_30PCT)
    else $error("regulated duty below 30 percent");
  AST_STEP_LIM: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode == MODE_REG && $past(mode == MODE_REG) && !$past(spin_done)
    && $past(reg_duty_ff) >= DUTY_30PCT
    |-> reg_duty_ff - $past(reg_duty_ff) <= 8'h04
     || $past(reg_duty_ff) - reg_duty_ff <= 8'h04)
    else $error("regulation step too large");
  AST_OPEN_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode == MODE_OPEN && !spinup_active && !meas_start_ff
    && (!meas_en_ff || tach_power_mode_ff)
    |=> pwm_ff == $past(duty_value_reg_ff))
    else $error("open-loop duty not kept as written");
  AST_REG_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
    mode == MODE_REG && !meas_en_ff && !spinup_active && !meas_start_ff
    |=> $stable(pwm_ff))
    else $error("regulation acted without speed measurement");

endmodule : fan_spinup_and_speed_mode_ctl

// *** tb/fan_spinup_and_speed_mode_ctl_tb.sv ***
`timescale 1ns/1ps
module fan_spinup_and_speed_mode_ctl_tb
  import fan_ctl_pkg::*;
;
  logic        ref_clk        = 1'b0;
  logic        nrst           = 1'b0;
  logic [7:0]  avs_address    = 8'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        fan_start_req  = 1'b0;
  logic [7:0]  remote_duty    = 8'h60;
  logic [7:0]  local_duty     = 8'h60;
  logic        measure_now    = 1'b0;
  logic [15:0] run_count      = 16'h0100;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] meas_count;
  logic        meas_valid;
  logic [7:0]  fan_pwm_duty;
  logic        speed_measure_start;
  logic        spinup_active;
  logic [31:0] rdata;
  int          n_mismatch     = 0;
  int          total_checks   = 0;

  always #12.5 ref_clk = ~ref_clk;

  fan_spinup_and_speed_mode_ctl fan_spinup_and_speed_mode_ctl_inst (
    .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .measured_speed_count(meas_count), .speed_count_valid(meas_valid),
    .fan_start_req(fan_start_req), .remote_temp_duty(remote_duty),
    .local_temp_duty(local_duty), .fan_pwm_duty(fan_pwm_duty),
    .speed_measure_start(speed_measure_start),
    .spinup_active(spinup_active));

  fan_tach_model fan_tach_model_inst (
    .ref_clk(ref_clk), .nrst(nrst), .pwm_duty(fan_pwm_duty),
    .measure_start(speed_measure_start), .measure_now(measure_now),
    .run_count(run_count), .tach_count(meas_count),
    .tach_valid(meas_valid));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 20) begin
      n_mismatch++;
      complete_run();
    end
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  task automatic do_reset();
    nrst <= 1'b0;
    cycles(5);
    nrst <= 1'b1;
    cycles(1);
  endtask : do_reset

  task automatic tach(input logic [15:0] c);
    run_count   <= c;
    measure_now <= 1'b1;
    cycles(1);
    measure_now <= 1'b0;
    cycles(8);
  endtask : tach

  task automatic start_pulse();
    fan_start_req <= 1'b1;
    cycles(1);
    fan_start_req <= 1'b0;
    cycles(4);
  endtask : start_pulse

  task automatic test_regs();
    rd(ADDR_FANCHAR);
    check(rdata & 32'h27, {29'h0, SPIN_TIME_RST});
    rd(ADDR_CFG1);
    check(rdata & 32'h3, {30'h0, CTL_SEL_RST});
    rd(ADDR_STATUS);
    check(rdata & 32'h6, 32'h4);
    rd(8'h7F);
    check(rdata, 32'h0);
    bus(1'b1, ADDR_DUTY, 32'h33, 4'h0);
    rd(ADDR_DUTY);
    check(rdata & 32'hFF, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FANCHAR, i);
      rd(ADDR_FANCHAR);
      check(rdata & 32'h7, i);
    end
    wr(ADDR_FANCHAR, SPIN_TIME_RST);
    $display("test regs done");
  endtask : test_regs

  task automatic test_open_loop();
    wr(ADDR_CFG1, 32'h0);
    wr(ADDR_DUTY, 32'h80);
    cycles(2);
    check(fan_pwm_duty, 8'h80);
    wr(ADDR_DUTY, DUTY_7PCT - 8'h1);
    cycles(2);
    check(fan_pwm_duty, 8'h00);
    wr(ADDR_DUTY, DUTY_7PCT);
    cycles(2);
    check(fan_pwm_duty, DUTY_7PCT);
    wr(ADDR_DUTY, 32'h11);
    wr(ADDR_STATUS, 32'h6);
    cycles(2);
    check(fan_pwm_duty, 8'h11);
    wr(ADDR_STATUS, 32'h0);
    cycles(2);
    check(fan_pwm_duty, 8'h11);
    wr(ADDR_STATUS, 32'h4);
    $display("test open loop done");
  endtask : test_open_loop

  task automatic test_auto();
    remote_duty <= 8'h90;
    local_duty  <= 8'hA0;
    wr(ADDR_CFG1, 32'h2);
    cycles(4);
    check(fan_pwm_duty, 8'h90);
    wr(ADDR_CFG1, 32'h3);
    cycles(4);
    check(fan_pwm_duty, 8'hA0);
    local_duty <= 8'h40;
    cycles(4);
    check(fan_pwm_duty, 8'h90);
    $display("test auto done");
  endtask : test_auto

  task automatic test_regulate();
    // target kept well inside what 30% duty can reach
    wr(ADDR_TARGET, 32'h0100);
    wr(ADDR_CFG1, 32'h0);
    wr(ADDR_DUTY, 32'hC0);
    wr(ADDR_STATUS, 32'h0);
    wr(ADDR_CFG1, 32'h1);
    cycles(2);
    check(fan_pwm_duty, 8'hC0);
    wr(ADDR_STATUS, 32'h4);
    cycles(2);
    check(fan_pwm_duty, DUTY_30PCT);
    $display("test regulate done");
  endtask : test_regulate

  task automatic test_spinup();
    wr(ADDR_CFG1, 32'h0);
    wr(ADDR_DUTY, 32'h80);
    start_pulse();
    check(spinup_active, 1'b1);
    check(fan_pwm_duty, DUTY_THIRD);
    check(speed_measure_start, 1'b0);
    cycles(200);
    // ramp steps are far apart, so the start value still holds
    check(fan_pwm_duty, DUTY_THIRD);
    rd(ADDR_TEMPDUTY);
    check(rdata & 32'hF, 32'hA);
    wr(ADDR_LOWLIM, 32'h10);
    tach(16'h0200);
    rd(ADDR_STATUS);
    check(rdata & 32'h2, 32'h0);
    // a spin-up lasts seconds; a second reset ends it early
    do_reset();
    check(spinup_active, 1'b0);
    $display("test spinup done");
  endtask : test_spinup

  task automatic test_disable();
    wr(ADDR_FANCHAR, 32'h25);
    rd(ADDR_FANCHAR);
    check(rdata & 32'h27, 32'h25);
    start_pulse();
    check(spinup_active, 1'b0);
    wr(ADDR_LOWLIM, 32'h100);
    tach(16'h0200);
    check(spinup_active, 1'b0);
    rd(ADDR_STATUS);
    check(rdata & 32'h2, 32'h2);
    rd(ADDR_STATUS);
    check(rdata & 32'h2, 32'h0);
    tach(16'h0200);
    tach(16'h0050);
    rd(ADDR_STATUS);
    check(rdata & 32'h2, 32'h2);
    rd(ADDR_STATUS);
    check(rdata & 32'h2, 32'h0);
    $display("test disable done");
  endtask : test_disable

  task automatic test_slow_spin();
    do_reset();
    wr(ADDR_LOWLIM, 32'h100);
    tach(16'h0200);
    check(spinup_active, 1'b1);
    check(fan_pwm_duty, DUTY_THIRD);
    $display("test slow spin done");
  endtask : test_slow_spin

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    cycles(6000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    do_reset();
    test_regs();
    test_open_loop();
    test_auto();
    test_regulate();
    test_spinup();
    test_disable();
    test_slow_spin();
    complete_run();
  end
endmodule : fan_spinup_and_speed_mode_ctl_tb

// *** tb/fan_tach_model.sv ***
`timescale 1ns/1ps
module fan_tach_model
  import fan_ctl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  pwm_duty,
  input  wire logic        measure_start,
  input  wire logic        measure_now,
  input  wire logic [15:0] run_count,
  output logic      [15:0] tach_count,
  output logic             tach_valid
);
  logic [2:0] delay_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      delay_ff   <= 3'h0;
      tach_valid <= 1'b0;
      tach_count <= 16'h0000;
    end else begin
      tach_valid <= 1'b0;
      if (measure_start || measure_now) begin
        delay_ff <= 3'h4;
      end else if (delay_ff != 3'h0) begin
        delay_ff <= delay_ff - 3'h1;
      end
      if (delay_ff == 3'h1) begin
        tach_valid <= 1'b1;
        // a stopped fan gives no tach edges, so the counter saturates
        tach_count <= (pwm_duty == 8'h00) ? 16'hFFFF : run_count;
      end else begin
        // outside the valid pulse the count is not to be trusted
        tach_count <= ~tach_count;
      end
    end
  end
endmodule : fan_tach_model
